// ===== rtl/csi_status_top.sv
// CANopen slave status indicators, rotary-switch boot check, pairing.
// Assumes all inputs synchronous to sys_clk_i; stack events are pulses.
`timescale 1ns/1ps
module csi_status_top
  import csi_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic boot_i,
  input wire logic ready_i,
  input wire logic init_mode_ok_i,
  input wire logic [3:0] id_hi_sw_i,
  input wire logic [3:0] id_lo_sw_i,
  input wire logic [3:0] baud_sw_i,
  input wire logic [1:0] nmt_state_i,
  input wire logic [SLOTS-1:0] slot_present_i,
  input wire logic cfg_reset_i,
  input wire logic err_warn_i,
  input wire logic guard_evt_i,
  input wire logic hb_evt_i,
  input wire logic err_clear_i,
  input wire logic sync_rx_i,
  input wire logic [31:0] cycle_period_i,
  input wire logic bus_off_i,
  input wire logic [DIO_W-1:0] partner_digital_input_channel_i,
  input wire logic partner_valid_i,
  output logic run_led_o,
  output logic err_led_o,
  output logic [7:0] node_id_o,
  output logic [9:0] bitrate_kbps_o,
  output logic init_mode_o,
  output logic pair_mode_o,
  output logic boot_ok_o,
  output logic boot_fail_o,
  output logic auto_start_o,
  output logic [SLOTS-1:0] pdo_enable_o,
  output logic [DIO_W-1:0] do_out_o
);

  csi_pat_if run_if ();
  csi_pat_if err_if ();
  csi_boot_t boot_ff;
  logic [SLOTS-1:0] slots_ff;
  logic mod_err_ff;
  logic evt_ff;
  logic sync_err_ff;
  logic [31:0] sync_cnt_ff;
  logic [6:0] us_ff;
  logic [7:0] sw_id;
  logic id_ok;
  logic id_pair;
  logic baud_ok;
  logic baud_init;

  csi_pat_gen u_run (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .p(run_if.gen)
  );

  csi_pat_gen u_err (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .p(err_if.gen)
  );

  // ------------------------------------------------------------
  // Switch decode
  // ------------------------------------------------------------
  always_comb
  begin
    sw_id = {id_hi_sw_i, id_lo_sw_i};
    id_pair = (sw_id >= ID_PAIR_MIN) && (sw_id <= ID_PAIR_MAX);
    id_ok = ((sw_id >= ID_NORM_MIN) && (sw_id <= ID_NORM_MAX)) || id_pair;
    baud_init = (baud_sw_i == BAUD_INIT) && init_mode_ok_i;
    baud_ok = (baud_sw_i <= BAUD_MAX) || baud_init;
  end

  // ------------------------------------------------------------
  // Boot sequence
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      boot_ff <= BOOT_IDLE;
      node_id_o <= 8'h00;
      bitrate_kbps_o <= 10'h000;
      init_mode_o <= 1'b0;
      pair_mode_o <= 1'b0;
      slots_ff <= '0;
      pdo_enable_o <= '0;
    end
    else if (ce_i)
    begin
      case (boot_ff)
        BOOT_IDLE:
          if (boot_i)
          begin
            if (id_ok && baud_ok)
            begin
              boot_ff <= BOOT_SCAN;
              node_id_o <= sw_id;
              bitrate_kbps_o <= csi_kbps(baud_sw_i);
              init_mode_o <= baud_init;
              pair_mode_o <= id_pair;
            end
            else
              boot_ff <= BOOT_FAIL;
          end
        BOOT_SCAN:
        begin
          slots_ff <= slot_present_i;
          pdo_enable_o <= slot_present_i;
          boot_ff <= BOOT_RUN;
        end
        BOOT_RUN:
          if (cfg_reset_i)
          begin
            slots_ff <= slot_present_i;
            pdo_enable_o <= slot_present_i;
          end
        BOOT_FAIL:
          boot_ff <= BOOT_FAIL;
        default:
          boot_ff <= BOOT_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      boot_ok_o <= 1'b0;
      boot_fail_o <= 1'b0;
      auto_start_o <= 1'b0;
    end
    else if (ce_i)
    begin
      boot_ok_o <= (boot_ff == BOOT_RUN);
      boot_fail_o <= (boot_ff == BOOT_FAIL);
      auto_start_o <= (boot_ff == BOOT_RUN) && pair_mode_o;
    end
  end

  // ------------------------------------------------------------
  // Module supervision
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      mod_err_ff <= 1'b0;
    else if (ce_i)
    begin
      if (boot_ff == BOOT_RUN && slot_present_i != slots_ff && !cfg_reset_i)
        mod_err_ff <= 1'b1;
      else if (cfg_reset_i)
        mod_err_ff <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Fault sources
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      evt_ff <= 1'b0;
    else if (ce_i)
    begin
      if (guard_evt_i || hb_evt_i)
        evt_ff <= 1'b1;
      else if (err_clear_i)
        evt_ff <= 1'b0;
    end
  end

  // SYNC watchdog counts microseconds; period 0 disables it
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      us_ff <= 7'h00;
      sync_cnt_ff <= 32'h0000_0000;
      sync_err_ff <= 1'b0;
    end
    else if (ce_i)
    begin
      us_ff <= (us_ff == 7'(CLK_HZ / 1000000 - 1)) ? 7'h00 : us_ff + 7'h01;
      if (sync_rx_i || cycle_period_i == 32'h0000_0000)
      begin
        sync_cnt_ff <= 32'h0000_0000;
        sync_err_ff <= 1'b0;
      end
      else if (sync_cnt_ff >= cycle_period_i)
        sync_err_ff <= 1'b1;
      else if (us_ff == 7'h00)
        sync_cnt_ff <= sync_cnt_ff + 32'h0000_0001;
    end
  end

  // ------------------------------------------------------------
  // Pattern selection
  // ------------------------------------------------------------
  always_comb
  begin
    if (!ready_i || boot_ff != BOOT_RUN)
      run_if.pat = PAT_OFF;
    else if (mod_err_ff)
      run_if.pat = PAT_RAPID;
    else if (pair_mode_o)
      run_if.pat = PAT_ON;
    else
    begin
      case (nmt_state_i)
        NMT_STOPPED: run_if.pat = PAT_SINGLE;
        NMT_PREOP: run_if.pat = PAT_BLINK;
        NMT_OPER: run_if.pat = PAT_ON;
        default: run_if.pat = PAT_OFF;
      endcase
    end
    if (bus_off_i)
      err_if.pat = PAT_ON;
    else if (sync_err_ff)
      err_if.pat = PAT_TRIPLE;
    else if (evt_ff)
      err_if.pat = PAT_DOUBLE;
    else if (err_warn_i)
      err_if.pat = PAT_SINGLE;
    else
      err_if.pat = PAT_OFF;
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      run_led_o <= 1'b0;
      err_led_o <= 1'b0;
    end
    else if (ce_i)
    begin
      run_led_o <= run_if.lamp;
      err_led_o <= err_if.lamp;
    end
  end

  // ------------------------------------------------------------
  // Pair connection: partner inputs drive our outputs
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      do_out_o <= '0;
    else if (ce_i)
    begin
      if (!pair_mode_o || boot_ff != BOOT_RUN)
        do_out_o <= '0;
      else if (partner_valid_i)
        do_out_o <= partner_digital_input_channel_i;
    end
  end

endmodule : csi_status_top

// ===== pkg/csi_pkg.sv
// Constants and types for the CANopen status indicator block.
// Assumes a 125 MHz system clock.
package csi_pkg;

  localparam int CLK_HZ = 125000000;
  localparam int FLASH_MS = 200;
  localparam int GAP_MS = 1000;
  localparam int RAPID_MS = 50;
  localparam int FLASH_CYC = FLASH_MS * (CLK_HZ / 1000);
  localparam int GAP_CYC = GAP_MS * (CLK_HZ / 1000);
  localparam int RAPID_CYC = RAPID_MS * (CLK_HZ / 1000);
  localparam int TMR_W = 28;

  localparam logic [7:0] ID_NORM_MIN = 8'h01;
  localparam logic [7:0] ID_NORM_MAX = 8'h7F;
  localparam logic [7:0] ID_PAIR_MIN = 8'h81;
  localparam logic [7:0] ID_PAIR_MAX = 8'hFE;
  localparam logic [3:0] BAUD_MAX = 4'h7;
  localparam logic [3:0] BAUD_INIT = 4'h9;
  localparam int DIO_W = 8;
  localparam int SLOTS = 8;

  // Network-management states
  localparam logic [1:0] NMT_STOPPED = 2'h0;
  localparam logic [1:0] NMT_PREOP = 2'h1;
  localparam logic [1:0] NMT_OPER = 2'h2;
  localparam logic [1:0] NMT_INIT = 2'h3;

  // Indicator patterns
  typedef enum logic [7:0] {
    PAT_OFF = 8'h01,
    PAT_SINGLE = 8'h02,
    PAT_DOUBLE = 8'h04,
    PAT_TRIPLE = 8'h08,
    PAT_BLINK = 8'h10,
    PAT_RAPID = 8'h20,
    PAT_ON = 8'h40
  } csi_pat_t;

  // Boot sequence states
  typedef enum logic [3:0] {
    BOOT_IDLE = 4'h1,
    BOOT_SCAN = 4'h2,
    BOOT_RUN = 4'h4,
    BOOT_FAIL = 4'h8
  } csi_boot_t;

  // Kbit/s for each legal bit-rate setting
  function automatic logic [9:0] csi_kbps(input logic [3:0] sel);
    case (sel)
      4'h0: csi_kbps = 10'h00A;
      4'h1: csi_kbps = 10'h014;
      4'h2: csi_kbps = 10'h032;
      4'h3: csi_kbps = 10'h07D;
      4'h4: csi_kbps = 10'h0FA;
      4'h5: csi_kbps = 10'h1F4;
      4'h6: csi_kbps = 10'h320;
      4'h7: csi_kbps = 10'h3E8;
      default: csi_kbps = 10'h000;
    endcase
  endfunction : csi_kbps

endpackage : csi_pkg

// ===== pkg/csi_pat_if.sv
// Pattern request and lamp output between top and pattern generator.
// Assumes one shared clock.
`timescale 1ns/1ps
interface csi_pat_if;
  import csi_pkg::*;
  csi_pat_t pat;
  logic lamp;
  modport ctrl (output pat, input lamp);
  modport gen (input pat, output lamp);
endinterface : csi_pat_if

// ===== rtl/csi_pat_gen.sv
// Indicator pattern generator: flashes, blinking, rapid blink, steady.
// Assumes synchronous active-high reset and a clock enable.
`timescale 1ns/1ps
module csi_pat_gen
  import csi_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  csi_pat_if.gen p
);

  csi_pat_t pat_ff;
  logic [TMR_W-1:0] tmr_ff;
  logic [2:0] ph_ff;
  logic lamp_ff;
  logic [2:0] nflash;
  logic [TMR_W-1:0] ph_len;
  logic last_ph;

  always_comb
  begin
    case (p.pat)
      PAT_SINGLE: nflash = 3'h1;
      PAT_DOUBLE: nflash = 3'h2;
      PAT_TRIPLE: nflash = 3'h3;
      default: nflash = 3'h0;
    endcase
    // Even phases lit, odd phases dark; last dark phase is the long gap
    last_ph = (ph_ff == 3'(2 * nflash - 3'h1));
    if (p.pat == PAT_RAPID)
      ph_len = TMR_W'(RAPID_CYC - 1);
    else if (nflash != 3'h0 && last_ph)
      ph_len = TMR_W'(GAP_CYC - 1);
    else
      ph_len = TMR_W'(FLASH_CYC - 1);
  end

  // ------------------------------------------------------------
  // Phase sequencing
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      pat_ff <= PAT_OFF;
      tmr_ff <= '0;
      ph_ff <= 3'h0;
    end
    else if (ce_i)
    begin
      pat_ff <= p.pat;
      if (p.pat != pat_ff)
      begin
        tmr_ff <= '0;
        ph_ff <= 3'h0;
      end
      else if (tmr_ff >= ph_len)
      begin
        tmr_ff <= '0;
        if (nflash == 3'h0 || last_ph)
          ph_ff <= (nflash == 3'h0) ? ph_ff + 3'h1 : 3'h0;
        else
          ph_ff <= ph_ff + 3'h1;
      end
      else
        tmr_ff <= tmr_ff + TMR_W'(1);
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      lamp_ff <= 1'b0;
    else if (ce_i)
    begin
      case (p.pat)
        PAT_OFF: lamp_ff <= 1'b0;
        PAT_ON: lamp_ff <= 1'b1;
        default: lamp_ff <= (p.pat == pat_ff) && !ph_ff[0];
      endcase
    end
  end

  assign p.lamp = lamp_ff;

endmodule : csi_pat_gen

// ===== tb/csi_chk_sva.sv
// Port checker for csi_status_top.
// Bound to every csi_status_top instance.
`timescale 1ns/1ps
module csi_chk
  import csi_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic boot_i,
  input wire logic ready_i,
  input wire logic init_mode_ok_i,
  input wire logic [3:0] id_hi_sw_i,
  input wire logic [3:0] id_lo_sw_i,
  input wire logic [3:0] baud_sw_i,
  input wire logic bus_off_i,
  input wire logic [DIO_W-1:0] partner_digital_input_channel_i,
  input wire logic partner_valid_i,
  input wire logic run_led_o,
  input wire logic err_led_o,
  input wire logic [7:0] node_id_o,
  input wire logic [9:0] bitrate_kbps_o,
  input wire logic init_mode_o,
  input wire logic boot_ok_o,
  input wire logic boot_fail_o,
  input wire logic pair_mode_o,
  input wire logic auto_start_o,
  input wire logic [DIO_W-1:0] do_out_o
);
  logic taken_ff;
  logic [7:0] id;
  logic ill;
  logic take;
  assign id = {id_hi_sw_i, id_lo_sw_i};
  assign ill = id == 8'h00 || id == 8'h80 || id == 8'hFF ||
    (baud_sw_i > BAUD_MAX && !(baud_sw_i == BAUD_INIT && init_mode_ok_i));
  assign take = boot_i && ce_i && !taken_ff;
  // Boot is taken once per reset
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      taken_ff <= 1'b0;
    else if (take)
      taken_ff <= 1'b1;
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  sequence good_take_s;
    take && !ill;
  endsequence
  boot_fail_a: assert property (take && ill |-> ##2 boot_fail_o)
    else $error("no boot failure after illegal switches");
  boot_ok_a: assert property (good_take_s |-> ##3 boot_ok_o)
    else $error("no boot success after legal switches");
  node_id_a: assert property (good_take_s |=> node_id_o == $past(id))
    else $error("node id not switch nibbles");
  init_mode_a: assert property (good_take_s ##0 baud_sw_i == BAUD_INIT
    |=> init_mode_o && bitrate_kbps_o == 10'h000)
    else $error("initial mode not selected");
  auto_start_a: assert property ($rose(boot_ok_o) && pair_mode_o
    |-> auto_start_o)
    else $error("paired node did not start by itself");
  do_zero_a: assert property (!auto_start_o |-> do_out_o == '0)
    else $error("outputs driven outside pair mode");
  do_copy_a: assert property (auto_start_o && partner_valid_i
    |=> do_out_o == $past(partner_digital_input_channel_i))
    else $error("outputs do not follow partner inputs");
  run_dark_a: assert property (!ready_i [*3] |-> !run_led_o)
    else $error("run lamp lit while not ready");
  bus_off_a: assert property ((boot_ok_o && bus_off_i) [*3] |-> err_led_o)
    else $error("fault lamp dark during bus-off");
endmodule : csi_chk

bind csi_status_top csi_chk u_chk (.*);

// ===== tb/csi_peer_node.sv
// Paired far node sending its input channel states.
// Driven by the bench through the send task.
`timescale 1ns/1ps
module csi_peer_node
  import csi_pkg::*;
#(
  parameter logic [7:0] PEER_ID = 8'h82 // Even mate of odd ID
)
(
  input wire logic sys_clk_i,
  output logic [DIO_W-1:0] din_o,
  output logic valid_o
);
  initial
  begin
    din_o = '0;
    valid_o = 1'b0;
  end
  task automatic send(input logic [DIO_W-1:0] val);
    @(posedge sys_clk_i);
    #1;
    din_o = val;
    valid_o = 1'b1;
    @(posedge sys_clk_i);
    #1;
    valid_o = 1'b0;
    // Stale data once released
    din_o = ~val;
  endtask : send
endmodule : csi_peer_node

// ===== tb/tb.sv
// Self-checking bench for csi_status_top.
// Uses csi_peer_node as the paired far node.
`timescale 1ns/1ps
module tb;
  import csi_pkg::*;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic boot_i = 1'b0;
  logic ready_i = 1'b0;
  logic iok = 1'b0;
  logic [3:0] hi = 4'h0;
  logic [3:0] lo = 4'h0;
  logic [3:0] baud = 4'h0;
  logic [1:0] nmt = 2'h0;
  logic [SLOTS-1:0] slots = 8'hA5;
  logic warn = 1'b0;
  logic guard = 1'b0;
  logic hb = 1'b0;
  logic eclr = 1'b0;
  logic boff = 1'b0;
  logic cfgr = 1'b0;
  logic srx = 1'b0;
  logic [31:0] cper = 32'h0000_0000;
  logic [DIO_W-1:0] pdin;
  logic pval;
  logic run_led, err_led, initm, pair, boot_ok, boot_fail, auto_st;
  logic [7:0] nid;
  logic [9:0] kbps;
  logic [SLOTS-1:0] pdo;
  logic [DIO_W-1:0] dout;
  int miscompares = 0;
  int n_compared = 0;
  int cyc = 0;
  logic [7:0] bad_id [7] = '{8'h00, 8'h80, 8'hFF, 8'h01, 8'h01, 8'h01, 8'h01};
  logic [3:0] bad_bd [7] = '{4'h0, 4'h0, 4'h0, 4'h8, 4'h9, 4'hA, 4'hF};
  logic [9:0] rate [8] = '{10'h00A, 10'h014, 10'h032, 10'h07D, 10'h0FA,
    10'h1F4, 10'h320, 10'h3E8};

  csi_status_top u_dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .ce_i(1'b1),
    .boot_i(boot_i), .ready_i(ready_i), .init_mode_ok_i(iok),
    .id_hi_sw_i(hi), .id_lo_sw_i(lo), .baud_sw_i(baud), .nmt_state_i(nmt),
    .slot_present_i(slots), .cfg_reset_i(cfgr), .err_warn_i(warn),
    .guard_evt_i(guard), .hb_evt_i(hb), .err_clear_i(eclr),
    .sync_rx_i(srx), .cycle_period_i(cper), .bus_off_i(boff),
    .partner_digital_input_channel_i(pdin), .partner_valid_i(pval),
    .run_led_o(run_led), .err_led_o(err_led), .node_id_o(nid),
    .bitrate_kbps_o(kbps), .init_mode_o(initm), .pair_mode_o(pair),
    .boot_ok_o(boot_ok), .boot_fail_o(boot_fail), .auto_start_o(auto_st),
    .pdo_enable_o(pdo), .do_out_o(dout));
  csi_peer_node u_peer (.sys_clk_i(sys_clk_i), .din_o(pdin), .valid_o(pval));

  initial
  begin
    forever #4 sys_clk_i = ~sys_clk_i;
  end
  always @(posedge sys_clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      miscompares = miscompares + 1;
      test_done();
    end
  end

  task automatic test_done();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : test_done
  task automatic chk(input string nm, input logic [31:0] seen,
    input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("BAD %s exp %0h seen %0h", nm, exp, seen);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask : tick
  // Reset, set switches, pulse boot, wait past the answer
  task automatic boot(input logic [7:0] id, input logic [3:0] b,
    input logic ok);
    rst_i = 1'b1;
    {hi, lo} = id;
    baud = b;
    iok = ok;
    tick(10);
    rst_i = 1'b0;
    tick(1);
    boot_i = 1'b1;
    tick(1);
    boot_i = 1'b0;
    tick(4);
  endtask : boot

  initial
  begin
    for (int i = 0; i < 7; i++)
    begin
      boot(bad_id[i], bad_bd[i], 1'b0);
      chk("boot_fail", boot_fail, 1'b1);
      chk("boot_ok", boot_ok, 1'b0);
    end
    $display("test illegal done");
    for (int i = 0; i < 8; i++)
    begin
      slots = 8'(i * 37);
      boot({i[3:0], 4'hF - i[3:0]}, i[3:0], 1'b0);
      chk("boot_ok", boot_ok, 1'b1);
      chk("node_id", nid, {i[3:0], 4'hF - i[3:0]});
      chk("kbps", kbps, rate[i]);
      chk("pdo", pdo, slots);
    end
    $display("test bitrate done");
    boot(8'h01, BAUD_INIT, 1'b1);
    chk("init_mode", initm, 1'b1);
    chk("kbps", kbps, 10'h000);
    ready_i = 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      nmt = i[1:0];
      tick(3);
      chk("run_led", run_led, i != 3);
    end
    ready_i = 1'b0;
    nmt = NMT_OPER;
    tick(3);
    chk("run_led", run_led, 1'b0);
    chk("err_led", err_led, 1'b0);
    warn = 1'b1;
    tick(3);
    chk("err_led", err_led, 1'b1);
    boff = 1'b1;
    tick(3);
    chk("err_led", err_led, 1'b1);
    {boff, warn} = 2'b00;
    tick(3);
    chk("err_led", err_led, 1'b0);
    for (int j = 0; j < 2; j++)
    begin
      {guard, hb} = j ? 2'b10 : 2'b01;
      tick(1);
      {guard, hb} = 2'b00;
      tick(3);
      chk("err_led", err_led, 1'b1);
      eclr = 1'b1;
      tick(1);
      eclr = 1'b0;
      tick(3);
      chk("err_led", err_led, 1'b0);
    end
    ready_i = 1'b1;
    nmt = NMT_INIT;
    tick(3);
    chk("run_led", run_led, 1'b0);
    slots = slots ^ 8'h01;
    tick(4);
    chk("run_led", run_led, 1'b1);
    slots = slots ^ 8'h01;
    tick(3);
    chk("run_led", run_led, 1'b1);
    slots = slots ^ 8'h02;
    cfgr = 1'b1;
    tick(1);
    cfgr = 1'b0;
    tick(3);
    chk("run_led", run_led, 1'b0);
    chk("pdo", pdo, slots);
    ready_i = 1'b0;
    // SYNC watchdog at 2 us with no SYNC arriving
    cper = 32'h0000_0002;
    tick(100);
    chk("err_led", err_led, 1'b0);
    tick(200);
    chk("err_led", err_led, 1'b1);
    guard = 1'b1;
    tick(1);
    guard = 1'b0;
    tick(3);
    chk("err_pat", u_dut.err_if.pat, PAT_TRIPLE);
    srx = 1'b1;
    tick(1);
    srx = 1'b0;
    tick(3);
    chk("err_pat", u_dut.err_if.pat, PAT_DOUBLE);
    cper = 32'h0000_0000;
    eclr = 1'b1;
    tick(1);
    eclr = 1'b0;
    tick(3);
    chk("err_led", err_led, 1'b0);
    $display("test lamps done");
    boot(8'h81, 4'h3, 1'b0);
    chk("pair", pair, 1'b1);
    chk("auto_start", auto_st, 1'b1);
    chk("peer_id", {nid[0], nid + 8'h01}, {1'b1, u_peer.PEER_ID});
    chk("do_out", dout, 8'h00);
    u_peer.send(8'h5A);
    chk("do_out", dout, 8'h5A);
    u_peer.send(8'hC3);
    chk("do_out", dout, 8'hC3);
    $display("test pair done");
    test_done();
  end
endmodule : tb
